// ===== core/standalone_supervisor.v
// Operating state, alarm enables, memory reset and card supervision
`timescale 1ns/1ps
`include "supervisor_regs.vh"

// How it works
// - Stand-alone needs card, option, no backplane
// - Stand-alone: control reads zero, no host status
// - Stand-alone: fault lamp on enabled diagnostics
// - Load image at power-up; run only in RUN
// - Host record applies now; stored restores later
// - Byte 0 bits 7..4 supply alarm enables
// - Byte 1 bit7 overrun, bit6 broken wire
// - Byte 2 bit n enables output n overload
// - Byte 3 bit 7 enables card diagnostic
// - Byte 4 process enables; bytes 5-7 unused
// - Memory reset reloads, clears outputs, counters
// - STOP, hold, return STOP, hold again
// - Card removal does not disturb host-requested RUN; stand-alone RUN stops
// - Power-up without card: STOP, no RUN
// - Card removal lights both fault lamps
// - Card fault clears only on validation
// - Power-up loads card image else debug
module standalone_supervisor #(
  parameter [31:0] MEMORY_RESET_POSITION_HOLD = `MEMORY_RESET_POSITION_HOLD_CYCLES, // Memory-reset hold cycles
  parameter [31:0] BLINK     = `BLINK_CYCLES      // Half period of STOP blink
) (
  input  wire        sys_clk_i,          // 125 MHz clock
  input  wire        rst_i,              // Power-up reset, active high
  input  wire        card_present_i,     // Card in slot (pin)
  input  wire        card_valid_i,       // Card content checks good (pin)
  input  wire        backplane_i,        // I/O backplane detected (pin)
  input  wire        switch_run_i,       // Mode switch at RUN (pin)
  input  wire        switch_memory_reset_position_i,      // Mode switch at memory_reset_position (pin)
  input  wire        standalone_cfg_i,   // Stand-alone option in stored config
  input  wire [63:0] stored_record_i,    // Stored alarm_enable_record
  input  wire        parameter_write_call_i, // Host record write strobe
  input  wire [63:0] parameter_data_i,   // Host record contents
  input  wire        host_run_i,         // Host RUN request level
  input  wire        host_download_i,    // Download strobe from host tool
  input  wire [31:0] host_ctrl_i,        // Host control data
  input  wire [31:0] status_i,           // Block status for host
  input  wire [3:0]  supply_fault_i,     // Aux, io, enc overload, enc loss
  input  wire [1:0]  encoder_fault_i,    // Frame overrun, broken wire
  input  wire [7:0]  output_ovl_i,       // Output overload per output
  input  wire [7:0]  process_event_i,    // Process interrupt events
  output reg         standalone_o,       // Stand-alone operation
  output reg         run_o,              // Program executing
  output reg         load_image_o,       // Pulse: load image into logic
  output reg         use_debug_image_o,  // Image source is internal debug
  output reg         clear_all_o,        // Pulse: outputs off, counters clear
  output reg [31:0]  ctrl_o,             // Control data as seen by logic
  output reg [31:0]  host_status_o,      // Status data to host
  output reg [15:0]  diag_alarm_o,       // Enabled diagnostic alarms to host
  output reg [7:0]   process_alarm_o,    // Enabled process alarms to host
  output reg         system_fault_indicator_o, // System fault lamp
  output reg         card_fault_indicator_o,   // Card fault lamp
  output reg         stop_indicator_o    // STOP lamp
);
  localparam [2:0] M_IDLE = 3'd0, M_HOLD1 = 3'd1, M_WAIT_STOP = 3'd2,
                   M_HOLD2 = 3'd3, M_BLINK = 3'd4;

  wire [4:0] pins_s;
  wire       card_s     = pins_s[0];
  wire       valid_s    = pins_s[1];
  wire       back_s     = pins_s[2];
  wire       sw_run_s   = pins_s[3];
  wire       sw_memory_reset_position_s  = pins_s[4];

  sync_2ff #(.W(5)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       ({switch_memory_reset_position_i, switch_run_i, backplane_i, card_valid_i, card_present_i}),
    .q_o       (pins_s)
  );

  reg [63:0] record_reg;
  reg        boot_reg;
  reg        card_ok_reg;
  reg        card_prev_reg;
  reg        card_fault_reg;
  reg        host_run_prev_reg;
  reg [2:0]  memory_reset_position_reg;
  reg [31:0] cnt_reg;
  reg [31:0] blink_cnt_reg;
  reg        blink_reg;
  reg        stop_lamp_reg;
  reg        validate_reg;

  // Enabled alarm conditions
  wire [63:0] rec_used = record_reg & `REC_USED_MASK;
  wire [15:0] diag_en = {
    4'h0,
    rec_used[`REC_CARD_DIAG_BIT] & card_fault_reg,
    rec_used[`REC_OUT_OVL_LSB +: 8] & output_ovl_i,
    rec_used[`REC_FRAME_OVERRUN_BIT] & encoder_fault_i[1],
    rec_used[`REC_BROKEN_WIRE_BIT] & encoder_fault_i[0],
    rec_used[`REC_AUX_SUPPLY_LOSS_BIT] & supply_fault_i[3] |
    rec_used[`REC_IO_SUPPLY_LOSS_BIT] & supply_fault_i[2] |
    rec_used[`REC_ENC_SUPPLY_OVL_BIT] & supply_fault_i[1] |
    rec_used[`REC_ENC_SUPPLY_LOSS_BIT] & supply_fault_i[0]
  };
  wire [7:0] proc_en = rec_used[`REC_PROC_ALARM_LSB +: 8] & process_event_i;

  // Stand-alone qualification
  wire sa_next = card_s & valid_s & standalone_cfg_i & ~back_s;
  wire run_ok  = sw_run_s & card_ok_reg & (sa_next | host_run_i) & (memory_reset_position_reg == M_IDLE);
  wire host_restart = host_run_i & ~host_run_prev_reg;
  wire memory_reset_position_done = (memory_reset_position_reg == M_HOLD2) && (cnt_reg >= MEMORY_RESET_POSITION_HOLD - 32'd1);

  // Boot, image load and card validation
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      boot_reg          <= 1'b1;
      card_ok_reg       <= 1'b0;
      card_prev_reg     <= 1'b0;
      card_fault_reg    <= 1'b0;
      validate_reg      <= 1'b0;
      load_image_o      <= 1'b0;
      use_debug_image_o <= 1'b1;
      clear_all_o       <= 1'b0;
    end else begin
      card_prev_reg <= card_s;
      boot_reg      <= 1'b0;
      validate_reg  <= boot_reg | host_download_i | memory_reset_position_done;
      load_image_o  <= boot_reg | memory_reset_position_done;
      clear_all_o   <= memory_reset_position_done;
      if (validate_reg) begin
        card_ok_reg       <= card_s & valid_s;
        use_debug_image_o <= ~(card_s & valid_s);
      end
      // Card removal sets fault and wins over validation clear
      if (card_prev_reg & ~card_s) begin
        card_fault_reg <= 1'b1;
      end else if (validate_reg & card_s & valid_s) begin
        card_fault_reg <= 1'b0;
      end else if (validate_reg & ~card_s) begin
        card_fault_reg <= 1'b1;
      end
    end
  end

  // Host parameter record, restored on host restart
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      record_reg        <= `REC_RESET_VALUE;
      host_run_prev_reg <= 1'b0;
    end else begin
      host_run_prev_reg <= host_run_i;
      if (boot_reg | host_restart) begin
        record_reg <= stored_record_i;
      end else if (parameter_write_call_i) begin
        record_reg <= parameter_data_i & `REC_USED_MASK;
      end
    end
  end

  // Memory-reset switch sequence
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      memory_reset_position_reg <= M_IDLE;
      cnt_reg  <= 32'd0;
    end else begin
      case (memory_reset_position_reg)
        M_IDLE: begin
          cnt_reg <= 32'd0;
          if (sw_memory_reset_position_s & ~run_o) begin
            memory_reset_position_reg <= M_HOLD1;
          end
        end
        M_HOLD1: begin
          if (~sw_memory_reset_position_s) begin
            memory_reset_position_reg <= (cnt_reg >= MEMORY_RESET_POSITION_HOLD - 32'd1) ? M_WAIT_STOP : M_IDLE;
            cnt_reg  <= 32'd0;
          end else if (cnt_reg < MEMORY_RESET_POSITION_HOLD - 32'd1) begin
            cnt_reg <= cnt_reg + 32'd1;
          end
        end
        M_WAIT_STOP: begin
          if (sw_run_s) begin
            memory_reset_position_reg <= M_IDLE;
          end else if (sw_memory_reset_position_s) begin
            memory_reset_position_reg <= M_HOLD2;
          end
        end
        M_HOLD2: begin
          if (~sw_memory_reset_position_s) begin
            memory_reset_position_reg <= M_IDLE;
          end else if (memory_reset_position_done) begin
            memory_reset_position_reg <= M_BLINK;
          end else begin
            cnt_reg <= cnt_reg + 32'd1;
          end
        end
        M_BLINK: begin
          memory_reset_position_reg <= M_IDLE;
        end
        default: memory_reset_position_reg <= M_IDLE;
      endcase
    end
  end

  // STOP lamp with off pulse and blink during reset
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      blink_cnt_reg <= 32'd0;
      blink_reg     <= 1'b1;
      stop_lamp_reg <= 1'b1;
    end else begin
      if (memory_reset_position_reg == M_HOLD2) begin
        if (blink_cnt_reg >= BLINK - 32'd1) begin
          blink_cnt_reg <= 32'd0;
          blink_reg     <= ~blink_reg;
        end else begin
          blink_cnt_reg <= blink_cnt_reg + 32'd1;
        end
      end else begin
        blink_cnt_reg <= 32'd0;
        blink_reg     <= 1'b1;
      end
      if (memory_reset_position_reg == M_HOLD1) begin
        stop_lamp_reg <= (cnt_reg >= MEMORY_RESET_POSITION_HOLD - 32'd1);
      end else if (memory_reset_position_reg == M_HOLD2) begin
        stop_lamp_reg <= blink_reg;
      end else begin
        stop_lamp_reg <= ~run_ok;
      end
    end
  end

  // Registered outputs
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      standalone_o             <= 1'b0;
      run_o                    <= 1'b0;
      ctrl_o                   <= 32'h0000_0000;
      host_status_o            <= 32'h0000_0000;
      diag_alarm_o             <= 16'h0000;
      process_alarm_o          <= 8'h00;
      system_fault_indicator_o <= 1'b0;
      card_fault_indicator_o   <= 1'b0;
      stop_indicator_o         <= 1'b1;
    end else begin
      standalone_o <= sa_next;
      run_o        <= run_ok & ~memory_reset_position_done;
      ctrl_o       <= sa_next ? 32'h0000_0000 : host_ctrl_i;
      host_status_o   <= sa_next ? 32'h0000_0000 : status_i;
      diag_alarm_o    <= sa_next ? 16'h0000 : diag_en;
      process_alarm_o <= sa_next ? 8'h00 : proc_en;
      system_fault_indicator_o <= card_fault_reg | (|diag_en);
      card_fault_indicator_o   <= card_fault_reg;
      stop_indicator_o         <= stop_lamp_reg;
    end
  end
endmodule // standalone_supervisor

// ===== include/supervisor_regs.vh
// Constants for the stand-alone and alarm-enable supervisor
`ifndef SUPERVISOR_REGS_VH
`define SUPERVISOR_REGS_VH
// Alarm-enable record field positions (byte*8 + bit)
`define REC_AUX_SUPPLY_LOSS_BIT    7
`define REC_IO_SUPPLY_LOSS_BIT     6
`define REC_ENC_SUPPLY_OVL_BIT     5
`define REC_ENC_SUPPLY_LOSS_BIT    4
`define REC_FRAME_OVERRUN_BIT      15
`define REC_BROKEN_WIRE_BIT        14
`define REC_OUT_OVL_LSB            16
`define REC_CARD_DIAG_BIT          31
`define REC_PROC_ALARM_LSB         32
`define REC_USED_MASK              64'h0000_00ff_80ff_c0f0
`define REC_RESET_VALUE            64'h0000_0000_0000_0000
// Memory-reset hold time in ms and cycles at 125 MHz
`define MEMORY_RESET_POSITION_HOLD_MS               3000
`define CLK_KHZ                    125000
`define MEMORY_RESET_POSITION_HOLD_CYCLES           (`MEMORY_RESET_POSITION_HOLD_MS * `CLK_KHZ)
`define BLINK_CYCLES               62500000
`endif

// ===== core/sync_2ff.v
// Two-flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module sync_2ff #(
  parameter W = 1
) (
  input  wire         sys_clk_i, // System clock
  input  wire         rst_i,     // Reset, unused by both stages
  input  wire [W-1:0] d_i,       // Asynchronous levels
  output reg  [W-1:0] q_o        // Synchronised levels
);
  reg [W-1:0] meta_reg;

  // First stage feeds only the second; no reset, so pin levels settle while reset holds
  // and boot validation sees the real card state
  always @(posedge sys_clk_i) begin
    meta_reg <= d_i;
    q_o      <= meta_reg;
  end
endmodule // sync_2ff

// ===== testbench/supervisor_asserts.sv
// Port assertions for the stand-alone supervisor
`timescale 1ns/1ps
module supervisor_asserts (
  input wire        sys_clk_i,                // Clock
  input wire        rst_i,                    // Reset
  input wire        card_present_i,           // Card pin
  input wire        backplane_i,              // Backplane pin
  input wire        switch_run_i,             // RUN pin
  input wire        parameter_write_call_i,   // Write strobe
  input wire [63:0] parameter_data_i,         // Record
  input wire        host_run_i,               // Host RUN
  input wire        host_download_i,          // Download
  input wire [3:0]  supply_fault_i,           // Supply faults
  input wire [7:0]  output_ovl_i,             // Overloads
  input wire [7:0]  process_event_i,          // Events
  input wire        standalone_o,             // Stand-alone
  input wire        run_o,                    // Running
  input wire        load_image_o,             // Load pulse
  input wire        clear_all_o,              // Clear pulse
  input wire [31:0] ctrl_o,                   // Control
  input wire [31:0] host_status_o,            // Status
  input wire [15:0] diag_alarm_o,             // Diag alarms
  input wire [7:0]  process_alarm_o,          // Proc alarms
  input wire        system_fault_indicator_o, // Fault lamp
  input wire        card_fault_indicator_o    // Card lamp
);
  reg wr_q1;
  reg wr_q2;
  reg run_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Write two cycles back that no restore overrode
  always @(posedge sys_clk_i) begin
    run_q <= host_run_i;
    wr_q1 <= parameter_write_call_i && !(host_run_i && !run_q);
    wr_q2 <= wr_q1;
  end
  AST_SA_QUIET: assert property (
    standalone_o && $past(standalone_o) |-> ctrl_o == 32'h0 && host_status_o == 32'h0 && process_alarm_o == 8'h0)
    else $error("host data not quiet in stand-alone");
  AST_SA_BACKPLANE: assert property (
    $past(backplane_i, 3) && $past(backplane_i, 4) && $past(backplane_i, 5) |-> !standalone_o)
    else $error("stand-alone with backplane present");
  AST_RUN_SWITCH: assert property (
    !$past(switch_run_i, 3) && !$past(switch_run_i, 4) && !$past(switch_run_i, 5) |-> !run_o)
    else $error("running with switch off RUN");
  AST_CLEAR_RELOAD: assert property (
    clear_all_o |-> load_image_o && !run_o)
    else $error("clear without reload");
  AST_SUPPLY_EN: assert property (
    wr_q2 && !standalone_o |-> diag_alarm_o[0] == |($past(supply_fault_i) & $past(parameter_data_i[7:4], 2)))
    else $error("supply alarm does not follow enables");
  AST_OVL_EN: assert property (
    wr_q2 && !standalone_o |-> diag_alarm_o[10:3] == ($past(output_ovl_i) & $past(parameter_data_i[23:16], 2)))
    else $error("overload alarms do not follow enables");
  AST_PROC_EN: assert property (
    wr_q2 && !standalone_o |-> process_alarm_o == ($past(process_event_i) & $past(parameter_data_i[39:32], 2)))
    else $error("process alarms do not follow enables");
  AST_CARD_OUT: assert property (
    $fell(card_present_i) |-> ##[1:8] card_fault_indicator_o && system_fault_indicator_o)
    else $error("card removal not signalled");
  AST_CARD_CLEAR: assert property (
    $fell(card_fault_indicator_o) |->
      $past(host_download_i, 2) || $past(host_download_i, 3) || $past(load_image_o) || $past(load_image_o, 2))
    else $error("card fault cleared without validation");
endmodule // supervisor_asserts
bind standalone_supervisor supervisor_asserts u_supervisor_asserts (
  .sys_clk_i, .rst_i, .card_present_i, .backplane_i, .switch_run_i, .parameter_write_call_i,
  .parameter_data_i, .host_run_i, .host_download_i, .supply_fault_i, .output_ovl_i, .process_event_i,
  .standalone_o, .run_o, .load_image_o, .clear_all_o, .ctrl_o, .host_status_o, .diag_alarm_o,
  .process_alarm_o, .system_fault_indicator_o, .card_fault_indicator_o);

// ===== testbench/host_model.sv
// Host controller model: record writes, RUN request, downloads
`timescale 1ns/1ps
module host_model (
  input  wire        sys_clk_i, // Clock
  output reg         wr_o,      // Record write strobe
  output reg  [63:0] data_o,    // Record contents
  output reg         run_o,     // RUN request level
  output reg         dl_o,      // Download pulse
  output reg  [31:0] ctrl_o     // Control data
);
  // Idle host
  initial begin
    wr_o = 1'b0;
    data_o = 64'h0;
    run_o = 1'b0;
    dl_o = 1'b0;
    ctrl_o = 32'h1234_5678;
  end
  // One-cycle write, whole record with the strobe
  task write_rec(input [63:0] d);
    @(posedge sys_clk_i) #1;
    wr_o = 1'b1;
    data_o = d;
    @(posedge sys_clk_i) #1;
    wr_o = 1'b0;
    data_o = ~d; // Released data does not linger
  endtask
  // RUN level; a rise restores the stored record
  task set_run(input r);
    @(posedge sys_clk_i) #1;
    run_o = r;
  endtask
  // Download pulse that triggers card validation
  task download;
    @(posedge sys_clk_i) #1;
    dl_o = 1'b1;
    @(posedge sys_clk_i) #1;
    dl_o = 1'b0;
  endtask
endmodule // host_model

// ===== testbench/test_standalone_mode_and_alarm_enables.sv
// Self-checking bench for the stand-alone supervisor
`timescale 1ns/1ps
module test_standalone_mode_and_alarm_enables;
  reg         sys_clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         card_present_i = 1'b1;
  reg         card_valid_i = 1'b1;
  reg         backplane_i = 1'b1;
  reg         switch_run_i = 1'b0;
  reg         switch_memory_reset_position_i = 1'b0;
  reg         standalone_cfg_i = 1'b0;
  reg  [63:0] stored_record_i = 64'h0000_0000_0000_0080;
  reg  [3:0]  supply_fault_i = 4'hf;
  reg  [1:0]  encoder_fault_i = 2'h3;
  reg  [7:0]  output_ovl_i = 8'hff;
  reg  [7:0]  process_event_i = 8'hff;
  wire        wr, run_h, dl, standalone_o, run_o, load_image_o, use_debug_image_o, clear_all_o;
  wire        system_fault_indicator_o, card_fault_indicator_o, stop_indicator_o;
  wire [63:0] data;
  wire [31:0] ctrl, ctrl_o, host_status_o;
  wire [15:0] diag_alarm_o;
  wire [7:0]  process_alarm_o;
  integer     error_cnt = 0;
  integer     cmp_count = 0;
  integer     cyc = 0;
  integer     i;
  reg         seen;
  host_model u_host_model (.sys_clk_i, .wr_o(wr), .data_o(data), .run_o(run_h), .dl_o(dl), .ctrl_o(ctrl));
  standalone_supervisor #(.MEMORY_RESET_POSITION_HOLD(32'd20), .BLINK(32'd4)) u_standalone_supervisor (
    .sys_clk_i, .rst_i, .card_present_i, .card_valid_i, .backplane_i, .switch_run_i, .switch_memory_reset_position_i,
    .standalone_cfg_i, .stored_record_i, .parameter_write_call_i(wr), .parameter_data_i(data),
    .host_run_i(run_h), .host_download_i(dl), .host_ctrl_i(ctrl), .status_i(32'hcafe_f00d),
    .supply_fault_i, .encoder_fault_i, .output_ovl_i, .process_event_i, .standalone_o, .run_o,
    .load_image_o, .use_debug_image_o, .clear_all_o, .ctrl_o, .host_status_o, .diag_alarm_o,
    .process_alarm_o, .system_fault_indicator_o, .card_fault_indicator_o, .stop_indicator_o);
  always #4 sys_clk_i = ~sys_clk_i;
  // Hang guard
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  task cyc_n(input integer n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task chk(input [8*8-1:0] name, input [31:0] exp, input [31:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0s expected %h seen %h", name, exp, got);
    end
  endtask
  // Diag alarms for a single enable bit with every supply, encoder and overload fault active and no card fault
  function [15:0] exp_diag(input integer b);
    exp_diag = 16'h0;
    if (b >= 4 && b <= 7) exp_diag = 16'h0001;
    if (b == 14) exp_diag = 16'h0002;
    if (b == 15) exp_diag = 16'h0004;
    if (b >= 16 && b <= 23) exp_diag = 16'h0008 << (b - 16);
  endfunction
  task wrap_up;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc_n(6);
    rst_i = 1'b0;
    cyc_n(3);
    chk("debug", 0, use_debug_image_o);
    for (i = 0; i < 64; i = i + 1) begin
      u_host_model.write_rec(64'h1 << i);
      cyc_n(1);
      chk("diag", exp_diag(i), diag_alarm_o);
      chk("proc", (i >= 32 && i < 40) ? 32'h1 << (i - 32) : 32'h0, process_alarm_o);
    end
    $display("record enables done");
    u_host_model.write_rec(64'h0);
    u_host_model.set_run(1'b1);
    cyc_n(3);
    chk("restore", 1, diag_alarm_o);
    chk("ctrl", 32'h1234_5678, ctrl_o);
    chk("status", 32'hcafe_f00d, host_status_o);
    switch_run_i = 1'b1;
    cyc_n(6);
    chk("run", 1, run_o);
    $display("restore and run done");
    card_present_i = 1'b0;
    cyc_n(7);
    chk("run", 1, run_o);
    chk("cardlamp", 1, card_fault_indicator_o);
    chk("syslamp", 1, system_fault_indicator_o);
    switch_run_i = 1'b0;
    cyc_n(6);
    chk("run", 0, run_o);
    switch_run_i = 1'b1;
    cyc_n(6);
    chk("run", 1, run_o);
    u_host_model.download;
    cyc_n(3);
    chk("cardlamp", 1, card_fault_indicator_o);
    u_host_model.write_rec(64'h0000_0000_8000_0000);
    cyc_n(1);
    chk("carddiag", 16'h0800, diag_alarm_o);
    u_host_model.set_run(1'b0);
    u_host_model.set_run(1'b1);
    card_present_i = 1'b1;
    cyc_n(5);
    chk("cardlamp", 1, card_fault_indicator_o);
    u_host_model.download;
    cyc_n(3);
    chk("cardlamp", 0, card_fault_indicator_o);
    $display("card removal done");
    backplane_i = 1'b0;
    standalone_cfg_i = 1'b1;
    cyc_n(6);
    chk("alone", 1, standalone_o);
    chk("ctrl", 0, ctrl_o);
    chk("status", 0, host_status_o);
    chk("diag", 0, diag_alarm_o);
    chk("syslamp", 1, system_fault_indicator_o);
    supply_fault_i = 4'h7;
    cyc_n(4);
    chk("syslamp", 0, system_fault_indicator_o);
    backplane_i = 1'b1;
    cyc_n(6);
    chk("alone", 0, standalone_o);
    $display("stand-alone done");
    switch_run_i = 1'b0;
    cyc_n(6);
    switch_memory_reset_position_i = 1'b1;
    cyc_n(10);
    chk("stoplamp", 0, stop_indicator_o);
    cyc_n(20);
    chk("stoplamp", 1, stop_indicator_o);
    switch_memory_reset_position_i = 1'b0;
    cyc_n(6);
    switch_memory_reset_position_i = 1'b1;
    seen = 1'b0;
    repeat (60) begin
      cyc_n(1);
      if (clear_all_o === 1'b1 && load_image_o === 1'b1) seen = 1'b1;
    end
    chk("memory_reset_position", 1, seen);
    switch_memory_reset_position_i = 1'b0;
    $display("memory reset done");
    card_present_i = 1'b0;
    rst_i = 1'b1;
    cyc_n(6);
    rst_i = 1'b0;
    switch_run_i = 1'b1;
    cyc_n(8);
    chk("run", 0, run_o);
    chk("debug", 1, use_debug_image_o);
    chk("cardlamp", 1, card_fault_indicator_o);
    card_present_i = 1'b1;
    cyc_n(4);
    u_host_model.download;
    cyc_n(6);
    chk("run", 1, run_o);
    $display("power cycle done");
    wrap_up;
  end
endmodule // test_standalone_mode_and_alarm_enables
